/* File: src/ccsd_regs.svh */
// register map, field positions, reset values and timing constants of the clock switch block
`ifndef CCSD_REGS_SVH
`define CCSD_REGS_SVH

// clock_switch_control index and byte address (index times four)
`define CCSD_CSC_INDEX        18'h0FFDE
`define CCSD_CSC_ADDR         18'h3FF78
`define CCSD_DIV_ADDR         18'h00000
`define CCSD_AUX_ADDR         18'h00004
`define CCSD_TRIM_ADDR        18'h00008
`define CCSD_IRQ_STAT_ADDR    18'h0000C
`define CCSD_IRQ_EN_ADDR      18'h00010
`define CCSD_IRQ_CLR_ADDR     18'h00014

// field positions
`define CCSD_DONE_BIT         7
`define CCSD_CRYSTAL_FOR_WATCHDOG_BIT       4
`define CCSD_DBL_BIT          3
`define CCSD_LOWPWR_BIT       7
`define CCSD_RCSEL_BIT        7
`define CCSD_IRQ_DONE_BIT     0
`define CCSD_IRQ_LOCK_BIT     1
`define CCSD_IRQ_RSVD_BIT     2

// reset values
`define CCSD_DIV_RESET        8'h00
`define CCSD_AUX_RESET        1'b0
`define CCSD_RCSEL_RESET      1'b0
`define CCSD_IRQ_RESET        3'h0

// source select codes
`define CCSD_SRC_EXT          3'h7
`define CCSD_SRC_WDOG         3'h4
`define CCSD_SRC_RC           3'h3
`define CCSD_SRC_XT_LOW       3'h2
`define CCSD_SRC_XT_MID       3'h1
`define CCSD_SRC_XT_HIGH      3'h0

// wake-up timing
`define CCSD_CLK_PERIOD_NS    4
`define CCSD_XTAL_OSC_CYC     1024
`define CCSD_XTAL_EXTRA_NS    60000
`define CCSD_RC_WAKE_NS       200000
`define CCSD_FAST_OSC_CYC     32

`endif

/* File: src/ccsd_pkg.sv */
// types shared by the clock switch block
package ccsd_pkg;

  typedef struct packed {
    logic       xtal_wdog;
    logic       rc_dbl;
    logic [2:0] src_sel;
  } ccsd_ctrl_t;

  typedef enum logic [1:0] {
    CCSD_ST_RUN  = 2'b01,
    CCSD_ST_WAKE = 2'b10
  } ccsd_state_t;

endpackage

/* File: src/ccsd_wakeup_timer.sv */
// wake-up timer: counts source ticks, then system cycles, then pulses done
module ccsd_wakeup_timer #(
  parameter int OSC_W  = 11,
  parameter int TIME_W = 17
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              start,
  input  wire logic              src_tick,
  input  wire logic [OSC_W-1:0]  osc_cycles,
  input  wire logic [TIME_W-1:0] time_cycles,
  output logic                   done
);
  initial
  begin
    if (OSC_W < 1 || TIME_W < 1)
      $error("ccsd_wakeup_timer: widths must be positive");
  end

  logic              busy_q;
  logic [OSC_W-1:0]  osc_cnt_q;
  logic [TIME_W-1:0] time_cnt_q;
  logic              osc_met;
  logic              time_met;

  assign osc_met  = (osc_cnt_q >= osc_cycles);
  assign time_met = (time_cnt_q >= time_cycles);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_q     <= 1'b0;
      osc_cnt_q  <= '0;
      time_cnt_q <= '0;
      done       <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        busy_q     <= 1'b1;
        osc_cnt_q  <= '0;
        time_cnt_q <= '0;
      end
      else if (busy_q)
      begin
        if (!osc_met)
        begin
          if (src_tick)
            osc_cnt_q <= osc_cnt_q + OSC_W'(1);
        end
        else if (!time_met)
          time_cnt_q <= time_cnt_q + TIME_W'(1);
        else
        begin
          busy_q <= 1'b0;
          done   <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: src/ccsd_clk_divider.sv */
// divides oscillator ticks by 2N (by one at N zero) into cpu ticks and halves them for peripherals
module ccsd_clk_divider #(
  parameter int DIV_W = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             osc_tick,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  cpu_tick,
  output logic                  periph_tick
);
  initial
  begin
    if (DIV_W < 1 || DIV_W > 16)
      $error("ccsd_clk_divider: DIV_W out of range");
  end

  logic [DIV_W:0] cnt_q;
  logic [DIV_W:0] limit;
  logic           cpu_hit;
  logic           phase_q;

  // terminal count 2N-1, recomputed every cycle so a new N applies at once
  assign limit   = {divisor, 1'b0} - (DIV_W + 1)'(1);
  assign cpu_hit = osc_tick && ((divisor == '0) || (cnt_q >= limit));

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (osc_tick)
      cnt_q <= cpu_hit ? '0 : cnt_q + (DIV_W + 1)'(1);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_tick    <= 1'b0;
      periph_tick <= 1'b0;
      phase_q     <= 1'b0;
    end
    else
    begin
      cpu_tick    <= cpu_hit;
      periph_tick <= cpu_hit && phase_q;
      if (cpu_hit)
        phase_q <= !phase_q;
    end
  end
endmodule

/* File: src/ccsd_top.sv */
// clock source switch and cpu clock divider with apb register access
//
// Chosen here: register access over APB.
`include "ccsd_regs.svh"

module ccsd_top #(
  parameter int XTAL_EXTRA_CYC = (`CCSD_XTAL_EXTRA_NS + `CCSD_CLK_PERIOD_NS - 1)
                                 / `CCSD_CLK_PERIOD_NS,
  parameter int RC_WAKE_CYC    = (`CCSD_RC_WAKE_NS + `CCSD_CLK_PERIOD_NS - 1)
                                 / `CCSD_CLK_PERIOD_NS,
  parameter int DIV_W          = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [17:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  input  wire logic [2:0]   user_config_one,
  input  wire logic         user_config_two,
  input  wire logic         wdog_osc_pin,
  input  wire logic         rc_osc_pin,
  input  wire logic         crystal_pin,
  input  wire logic         clock_in_pin,
  output ccsd_pkg::ccsd_ctrl_t active_cfg,
  output logic              crystal_for_watchdog,
  output logic              low_power_clock_bit,
  output logic              osc_clock,
  output logic              cpu_clock,
  output logic              periph_clock,
  output logic              irq
);
  import ccsd_pkg::*;

  localparam int TIME_W = 17;
  localparam int OSC_W  = 11;

  initial
  begin
    if (XTAL_EXTRA_CYC < 1 || XTAL_EXTRA_CYC >= (1 << TIME_W))
      $error("ccsd_top: XTAL_EXTRA_CYC does not fit the wake-up timer");
    if (RC_WAKE_CYC < 1 || RC_WAKE_CYC >= (1 << TIME_W))
      $error("ccsd_top: RC_WAKE_CYC does not fit the wake-up timer");
    if (DIV_W != 8)
      $error("ccsd_top: divisor register is eight bits wide");
  end

  // oscillator pins: two-stage synchronisers, then a third stage for edges
  localparam int NPIN = 4;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;
  logic [NPIN-1:0] sync3_q;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;

  assign pin_raw = {clock_in_pin, crystal_pin, rc_osc_pin, wdog_osc_pin};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_sync
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          sync3_q[gi] <= 1'b0;
        end
        else
        begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
        end
      end
      assign rise[gi] = sync2_q[gi] && !sync3_q[gi];
      assign fall[gi] = !sync2_q[gi] && sync3_q[gi];
    end
  endgenerate

  // register state
  ccsd_ctrl_t  req_q;
  ccsd_ctrl_t  act_q;
  ccsd_state_t state_q;
  logic        done_q;
  logic        strap_pend_q;
  logic [7:0]  div_q;
  logic        lowpwr_q;
  logic        rcsel_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_en_q;
  logic        wake_done;

  // apb decode
  logic        acc;
  logic        wr;
  logic        hit_csc;
  logic        hit_div;
  logic        hit_aux;
  logic        hit_trim;
  logic        hit_stat;
  logic        hit_en;
  logic        hit_clr;
  logic        mapped;
  logic        csc_locked;
  logic        sel_rsvd;
  logic        csc_write;
  logic        new_switch;
  ccsd_ctrl_t  wr_cfg;

  assign acc      = psel && penable;
  assign wr       = acc && pwrite;
  assign hit_csc  = (paddr == `CCSD_CSC_ADDR);
  assign hit_div  = (paddr == `CCSD_DIV_ADDR);
  assign hit_aux  = (paddr == `CCSD_AUX_ADDR);
  assign hit_trim = (paddr == `CCSD_TRIM_ADDR);
  assign hit_stat = (paddr == `CCSD_IRQ_STAT_ADDR);
  assign hit_en   = (paddr == `CCSD_IRQ_EN_ADDR);
  assign hit_clr  = (paddr == `CCSD_IRQ_CLR_ADDR);
  assign mapped   = hit_csc || hit_div || hit_aux || hit_trim || hit_stat || hit_en || hit_clr;

  assign wr_cfg.xtal_wdog = pwdata[`CCSD_CRYSTAL_FOR_WATCHDOG_BIT];
  assign wr_cfg.rc_dbl    = pwdata[`CCSD_DBL_BIT];
  assign wr_cfg.src_sel   = pwdata[2:0];

  // codes 101 and 110 are reserved
  assign sel_rsvd   = (wr_cfg.src_sel == 3'h5) || (wr_cfg.src_sel == 3'h6);
  assign csc_locked = !done_q;
  assign csc_write  = wr && hit_csc && !csc_locked && !sel_rsvd;
  assign new_switch = csc_write && ((wr_cfg.src_sel != req_q.src_sel)
                                    || (wr_cfg.rc_dbl != req_q.rc_dbl));

  assign pready  = 1'b1;
  assign pslverr = acc && (!mapped || (pwrite && hit_csc && (csc_locked || sel_rsvd))
                           || (pwrite && hit_stat) || (!pwrite && hit_clr));

  // clock_switch_control: strap load after reset, software writes when idle
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_pend_q <= 1'b1;
      req_q        <= '0;
    end
    else if (strap_pend_q)
    begin
      strap_pend_q  <= 1'b0;
      req_q.src_sel <= user_config_one;
      req_q.rc_dbl  <= user_config_two;
    end
    else if (csc_write)
      req_q <= wr_cfg;
  end

  // the watchdog crystal choice takes effect at once, no wake-up needed
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      crystal_for_watchdog <= 1'b0;
    else if (csc_write)
      crystal_for_watchdog <= wr_cfg.xtal_wdog;
  end

  // switch sequencer
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= CCSD_ST_RUN;
      done_q  <= 1'b1;
      act_q   <= '0;
    end
    else if (strap_pend_q)
    begin
      act_q.src_sel <= user_config_one;
      act_q.rc_dbl  <= user_config_two;
    end
    else
    begin
      act_q.xtal_wdog <= req_q.xtal_wdog;
      unique case (state_q)
        CCSD_ST_RUN:
        begin
          if (new_switch)
          begin
            state_q <= CCSD_ST_WAKE;
            done_q  <= 1'b0;
          end
        end
        CCSD_ST_WAKE:
        begin
          if (wake_done)
          begin
            act_q.src_sel <= req_q.src_sel;
            act_q.rc_dbl  <= req_q.rc_dbl;
            state_q       <= CCSD_ST_RUN;
            done_q        <= 1'b1;
          end
        end
      endcase
    end
  end

  // source tick selection for a given configuration
  function automatic logic src_tick_of(ccsd_ctrl_t cfg, logic [NPIN-1:0] r, logic [NPIN-1:0] f);
    logic t;
    t = 1'b0;
    case (cfg.src_sel)
      `CCSD_SRC_EXT:  t = r[3];
      `CCSD_SRC_WDOG: t = r[0];
      `CCSD_SRC_RC:   t = cfg.rc_dbl ? (r[1] || f[1]) : r[1];
      `CCSD_SRC_XT_LOW,
      `CCSD_SRC_XT_MID,
      `CCSD_SRC_XT_HIGH: t = r[2];
      default:        t = 1'b0;
    endcase
    return t;
  endfunction

  logic             rc_tick;
  logic             osc_tick;
  logic             div_cpu_tick;
  logic             div_per_tick;
  logic [OSC_W-1:0] wake_osc;
  logic [TIME_W-1:0] wake_time;

  assign osc_tick = src_tick_of(act_q, rise, fall);
  assign rc_tick  = act_q.rc_dbl ? (rise[1] || fall[1]) : rise[1];

  // wake-up delay chosen from the newly requested source
  always_comb
  begin
    wake_osc  = OSC_W'(`CCSD_FAST_OSC_CYC);
    wake_time = '0;
    if (req_q.src_sel == `CCSD_SRC_RC)
    begin
      wake_osc  = '0;
      wake_time = TIME_W'(RC_WAKE_CYC);
    end
    else if (req_q.src_sel == `CCSD_SRC_XT_LOW || req_q.src_sel == `CCSD_SRC_XT_MID
             || req_q.src_sel == `CCSD_SRC_XT_HIGH)
    begin
      wake_osc  = OSC_W'(`CCSD_XTAL_OSC_CYC);
      wake_time = TIME_W'(XTAL_EXTRA_CYC);
    end
  end

  ccsd_wakeup_timer #(
    .OSC_W  (OSC_W),
    .TIME_W (TIME_W)
  ) u_wake (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .start       (new_switch),
    .src_tick    (src_tick_of(req_q, rise, fall)),
    .osc_cycles  (wake_osc),
    .time_cycles (wake_time),
    .done        (wake_done)
  );

  ccsd_clk_divider #(
    .DIV_W (DIV_W)
  ) u_div (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .osc_tick    (rcsel_q ? rc_tick : osc_tick),
    .divisor     (rcsel_q ? '0 : div_q),
    .cpu_tick    (div_cpu_tick),
    .periph_tick (div_per_tick)
  );

  // rc select feeds rc ticks to the divider at N zero, so one phase serves both paths
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_clock    <= 1'b0;
      cpu_clock    <= 1'b0;
      periph_clock <= 1'b0;
    end
    else
    begin
      osc_clock    <= osc_tick;
      cpu_clock    <= div_cpu_tick;
      periph_clock <= div_per_tick;
    end
  end

  // divisor, low power and rc select registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= `CCSD_DIV_RESET;
    else if (wr && hit_div)
      div_q <= pwdata[7:0];
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      lowpwr_q <= `CCSD_AUX_RESET;
    else if (wr && hit_aux)
      lowpwr_q <= pwdata[`CCSD_LOWPWR_BIT];
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rcsel_q <= `CCSD_RCSEL_RESET;
    else if (wr && hit_trim)
      rcsel_q <= pwdata[`CCSD_RCSEL_BIT];
  end

  // interrupt status: set wins over clear
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  assign irq_set = {wr && hit_csc && sel_rsvd && !csc_locked,
                    wr && hit_csc && csc_locked,
                    wake_done};
  assign irq_clr = (wr && hit_clr) ? pwdata[2:0] : 3'h0;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      irq_stat_q <= `CCSD_IRQ_RESET;
    else
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      irq_en_q <= `CCSD_IRQ_RESET;
    else if (wr && hit_en)
      irq_en_q <= pwdata[2:0];
  end

  assign irq                 = |(irq_stat_q & irq_en_q);
  assign active_cfg          = act_q;
  assign low_power_clock_bit = lowpwr_q;

  // read data captured in the setup phase
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      prdata <= 32'h0000_0000;
      if (hit_csc)
        prdata[7:0] <= {done_q, 2'b00, req_q.xtal_wdog, req_q.rc_dbl, req_q.src_sel};
      else if (hit_div)
        prdata[7:0] <= div_q;
      else if (hit_aux)
        prdata[`CCSD_LOWPWR_BIT] <= lowpwr_q;
      else if (hit_trim)
        prdata[`CCSD_RCSEL_BIT] <= rcsel_q;
      else if (hit_stat)
        prdata[2:0] <= irq_stat_q;
      else if (hit_en)
        prdata[2:0] <= irq_en_q;
    end
  end
endmodule

/* File: tb/ccsd_top_asserts.sv */
// concurrent assertions on the clock switch block ports
`include "ccsd_regs.svh"
module ccsd_top_asserts (
  input wire logic                 clk_sys,
  input wire logic                 rst_n,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [17:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pslverr,
  input wire ccsd_pkg::ccsd_ctrl_t active_cfg,
  input wire logic                 crystal_for_watchdog,
  input wire logic                 low_power_clock_bit,
  input wire logic                 osc_clock,
  input wire logic                 cpu_clock,
  input wire logic                 periph_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  import ccsd_pkg::*;
  logic       wr;
  logic       csc_wr;
  logic       start;
  logic [4:0] since_q;
  logic [1:0] cnt_q;
  logic       seen_q;
  logic       rc_sel_q;
  assign wr     = psel && penable && pwrite;
  assign csc_wr = wr && paddr == `CCSD_CSC_ADDR;
  assign start  = csc_wr && !pslverr && pwdata[2:0] != active_cfg.src_sel;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      since_q  <= 5'h1F;
      cnt_q    <= 2'h0;
      seen_q   <= 1'b0;
      rc_sel_q <= 1'b0;
    end
    else
    begin
      if (start)
        since_q <= 5'h00;
      else if (since_q != 5'h1F)
        since_q <= since_q + 5'h01;
      if (periph_clock)
        cnt_q <= 2'h0;
      else if (cpu_clock && cnt_q != 2'h3)
        cnt_q <= cnt_q + 2'h1;
      if (periph_clock)
        seen_q <= 1'b1;
      if (wr && paddr == `CCSD_TRIM_ADDR)
        rc_sel_q <= pwdata[7];
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  reserved_code_a:
    assert property (csc_wr && pwdata[2:0] inside {3'h5, 3'h6} |-> pslverr)
    else $error("reserved select code accepted");
  busy_write_a:
    assert property (csc_wr && since_q < 5'h1E |-> pslverr)
    else $error("write accepted during switch");
  busy_flag_a:
    assert property (psel && penable && !pwrite && paddr == `CCSD_CSC_ADDR
                     && since_q < 5'h14 |-> !prdata[7])
    else $error("done flag high during switch");
  old_source_a:
    assert property (start |=> $stable(active_cfg.src_sel) [*8])
    else $error("source changed before wake-up");
  xtal_wdog_a:
    assert property (csc_wr && !pslverr |=> crystal_for_watchdog == $past(pwdata[4]))
    else $error("watchdog crystal bit not applied");
  lp_reset_a:
    assert property ($rose(rst_n) |-> !low_power_clock_bit)
    else $error("low power bit set after reset");
  periph_half_a:
    assert property (periph_clock && seen_q |->
                     (cnt_q == 2'h2 && !cpu_clock) || (cnt_q == 2'h1 && cpu_clock))
    else $error("peripheral tick not every second cpu tick");
  cpu_osc_a:
    assert property (cpu_clock && !rc_sel_q && !$past(rc_sel_q) && !$past(rc_sel_q, 2)
                     |-> $past(osc_clock))
    else $error("cpu tick without oscillator tick");
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the clock switch block
`include "ccsd_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ccsd_pkg::*;
  typedef struct packed {
    logic        w;
    logic [17:0] a;
    logic [31:0] d;
    logic        e;
  } ccsd_row_t;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [2:0]  user_config_one = 3'h7;
  logic        user_config_two = 1'b0;
  logic [7:0]  ph_q = 8'h00;
  logic        pready, pslverr, irq, osc_clock, cpu_clock, periph_clock;
  logic        crystal_for_watchdog, low_power_clock_bit;
  logic [31:0] prdata;
  ccsd_ctrl_t  active_cfg;
  int          errors = 0, checked = 0, cyc = 0;
  int          t0, n, co, cc, cp, x;
  logic [3:0]  sw_code [6] = '{4'h4, 4'hB, 4'h7, 4'h2, 4'h1, 4'h0};
  int          sw_min [6] = '{124, 40, 248, 2066, 2066, 2066};
  int          sw_per [6] = '{4, 8, 8, 2, 2, 2};
  int          dv [4] = '{0, 1, 3, 255};
  ccsd_row_t   rows [14] = '{
    '{1'b0, `CCSD_CSC_ADDR, 32'h87, 1'b0},
    '{1'b1, `CCSD_DIV_ADDR, 32'h05, 1'b0},
    '{1'b0, `CCSD_DIV_ADDR, 32'h05, 1'b0},
    '{1'b1, `CCSD_AUX_ADDR, 32'h80, 1'b0},
    '{1'b0, `CCSD_AUX_ADDR, 32'h80, 1'b0},
    '{1'b0, `CCSD_TRIM_ADDR, 32'h00, 1'b0},
    '{1'b1, `CCSD_IRQ_STAT_ADDR, 32'h01, 1'b1},
    '{1'b0, 18'h00020, 32'h00, 1'b1},
    '{1'b0, `CCSD_IRQ_CLR_ADDR, 32'h00, 1'b1},
    '{1'b1, `CCSD_CSC_ADDR, 32'h05, 1'b1},
    '{1'b0, `CCSD_CSC_ADDR, 32'h87, 1'b0},
    '{1'b0, `CCSD_IRQ_STAT_ADDR, 32'h04, 1'b0},
    '{1'b1, `CCSD_IRQ_CLR_ADDR, 32'h04, 1'b0},
    '{1'b0, `CCSD_IRQ_STAT_ADDR, 32'h00, 1'b0}};

  ccsd_top #(.XTAL_EXTRA_CYC(20), .RC_WAKE_CYC(40)) dut (
    .clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .user_config_one, .user_config_two, .wdog_osc_pin(ph_q[1]),
    .rc_osc_pin(ph_q[3]), .crystal_pin(ph_q[0]), .clock_in_pin(ph_q[2]), .active_cfg,
    .crystal_for_watchdog, .low_power_clock_bit, .osc_clock, .cpu_clock,
    .periph_clock, .irq);

  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    ph_q <= ph_q + 8'h01;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic op(input ccsd_row_t r);
    psel   <= 1'b1;
    pwrite <= r.w;
    paddr  <= r.a;
    pwdata <= r.w ? r.d : 32'h0;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    chk($sformatf("err %h", r.a), 32'(pslverr), 32'(r.e));
    if (!r.w && !r.e)
      chk($sformatf("rd %h", r.a), prdata, r.d);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic cnt(input int w);
    co = 0;
    cc = 0;
    cp = 0;
    repeat (w)
    begin
      @(posedge clk_sys);
      co += int'(osc_clock);
      cc += int'(cpu_clock);
      cp += int'(periph_clock);
    end
  endtask

  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("cfg", 32'(active_cfg), 32'h07);
    chk("lp", 32'(low_power_clock_bit), 32'h0);
    for (int i = 0; i < 14; i++)
      op(rows[i]);
    op('{1'b1, `CCSD_IRQ_EN_ADDR, 32'h1, 1'b0});
    for (int i = 0; i < 6; i++)
    begin
      t0 = cyc;
      op('{1'b1, `CCSD_CSC_ADDR, 32'(sw_code[i]), 1'b0});
      op('{1'b0, `CCSD_CSC_ADDR, 32'(sw_code[i]), 1'b0});
      op('{1'b1, `CCSD_CSC_ADDR, 32'h7, 1'b1});
      n = 0;
      while (active_cfg.src_sel !== sw_code[i][2:0] && n < 5000)
      begin
        @(posedge clk_sys);
        n++;
      end
      n = cyc - t0;
      chk("wake", 32'(n >= sw_min[i] && n <= sw_min[i] + 4 * sw_per[i] + 16), 32'h1);
      chk("irq", 32'(irq), 32'h1);
      op('{1'b0, `CCSD_CSC_ADDR, 32'h80 | 32'(sw_code[i]), 1'b0});
      op('{1'b1, `CCSD_IRQ_CLR_ADDR, 32'h7, 1'b0});
      chk("irq", 32'(irq), 32'h0);
      cnt(16 * sw_per[i]);
      chk("osc", 32'(co >= 15 && co <= 17), 32'h1);
    end
    for (int i = 0; i < 4; i++)
    begin
      op('{1'b1, `CCSD_DIV_ADDR, 32'(dv[i]), 1'b0});
      cnt(2040);
      x = dv[i] == 0 ? 1020 : 1020 / (2 * dv[i]);
      chk("cpu", 32'(cc >= x - 2 && cc <= x + 2), 32'h1);
      chk("per", 32'(cp >= cc / 2 - 1 && cp <= cc / 2 + 1), 32'h1);
    end
    op('{1'b1, `CCSD_TRIM_ADDR, 32'h80, 1'b0});
    cnt(240);
    chk("rcsel", 32'(cc >= 13 && cc <= 17), 32'h1);
    op('{1'b1, `CCSD_TRIM_ADDR, 32'h00, 1'b0});
    op('{1'b1, `CCSD_CSC_ADDR, 32'h10, 1'b0});
    chk("xwd", 32'(crystal_for_watchdog), 32'h1);
    op('{1'b0, `CCSD_CSC_ADDR, 32'h90, 1'b0});
    op('{1'b1, `CCSD_AUX_ADDR, 32'h80, 1'b0});
    chk("lp", 32'(low_power_clock_bit), 32'h1);
    user_config_one <= 3'h3;
    user_config_two <= 1'b1;
    rst_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("lp", 32'(low_power_clock_bit), 32'h0);
    chk("cfg", 32'(active_cfg), 32'h0B);
    op('{1'b0, `CCSD_CSC_ADDR, 32'h8B, 1'b0});
    op('{1'b1, `CCSD_CSC_ADDR, 32'h06, 1'b1});
    chk("irq", 32'(irq), 32'h0);
    op('{1'b1, `CCSD_IRQ_EN_ADDR, 32'h4, 1'b0});
    chk("irq", 32'(irq), 32'h1);
    op('{1'b1, `CCSD_IRQ_CLR_ADDR, 32'h4, 1'b0});
    chk("irq", 32'(irq), 32'h0);
    end_of_test();
  end
endmodule

bind ccsd_top ccsd_top_asserts chk_u (
  .clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr,
  .active_cfg, .crystal_for_watchdog, .low_power_clock_bit, .osc_clock, .cpu_clock,
  .periph_clock);
